// [rtl/tmr8_pkg.sv]
// shared constants, types and helpers of the 8-bit waveform timer
package tmr8_pkg;

   // ****************************************************************
   // counter limits
   // ****************************************************************
   localparam int TMR8_W = 8;
   localparam logic [7:0] TMR8_MAX = 8'hFF;
   localparam logic [7:0] TMR8_BOTTOM = 8'h00;
   localparam logic [7:0] TMR8_STEP = 8'h01;

   // ****************************************************************
   // waveform mode select encodings
   // ****************************************************************
   localparam logic [1:0] TMR8_MODE_NORMAL = 2'h0;
   localparam logic [1:0] TMR8_MODE_PHASE = 2'h1;
   localparam logic [1:0] TMR8_MODE_MATCH = 2'h2;
   localparam logic [1:0] TMR8_MODE_FAST = 2'h3;

   // ****************************************************************
   // output action select encodings
   // ****************************************************************
   localparam logic [1:0] TMR8_ACT_NONE = 2'h0;
   localparam logic [1:0] TMR8_ACT_TOGGLE = 2'h1;
   localparam logic [1:0] TMR8_ACT_CLEAR = 2'h2;
   localparam logic [1:0] TMR8_ACT_SET = 2'h3;

   // counting direction of the dual-slope mode
   typedef enum logic {TMR8_UP, TMR8_DOWN} tmr8_dir_t;

   // true for both pwm modes, where the compare value is buffered
   function automatic logic tmr8_is_pwm(input logic [1:0] mode);
      return (mode == TMR8_MODE_FAST) || (mode == TMR8_MODE_PHASE);
   endfunction : tmr8_is_pwm

   // level left by an up-counting match in pwm: high only when inverted
   function automatic logic tmr8_up_level(input logic [1:0] act);
      return act == TMR8_ACT_SET;
   endfunction : tmr8_up_level

endpackage : tmr8_pkg

// [rtl/tmr8_wavegen.sv]
// compare output waveform generator of the 8-bit timer
`timescale 1ns/10ps
`default_nettype none

module tmr8_wavegen
   import tmr8_pkg::*;
(
   input wire logic [1:0] mode,
   input wire logic [1:0] action,
   input wire logic oc,
   input wire logic tick,
   input wire logic match,
   input wire logic at_max,
   input wire logic at_bottom,
   input wire logic count_up,
   input wire logic ocr_max,
   input wire logic force_match,
   output logic next_oc
);

   // polarity of the pwm waveform
   logic up_lvl;
   assign up_lvl = tmr8_up_level(action);

   // ****************************************************************
   // next level of the compare output
   // ****************************************************************
   always_comb
   begin
      next_oc = oc;
      case (mode)
         // non-pwm: set, clear or toggle on a match or a forced match
         TMR8_MODE_NORMAL, TMR8_MODE_MATCH:
         begin
            if ((tick && match) || force_match)
            begin
               case (action)
                  TMR8_ACT_TOGGLE: next_oc = ~oc; // R5
                  TMR8_ACT_CLEAR: next_oc = 1'b0;
                  TMR8_ACT_SET: next_oc = 1'b1;
                  default: next_oc = oc; // R23
               endcase
            end
         end
         // single slope: the wrap wins over a match at max, so max is flat
         TMR8_MODE_FAST:
         begin
            if (tick && (action == TMR8_ACT_TOGGLE) && match)
            begin
               next_oc = ~oc; // R13
            end
            else if (tick && action[1])
            begin
               if (match)
               begin
                  next_oc = up_lvl; // R9 R10
               end
               if (at_max)
               begin
                  next_oc = ~up_lvl; // R9 R12
               end
            end
         end
         // dual slope: bottom counts as upward, max as upward unless ocr is max
         TMR8_MODE_PHASE:
         begin
            if (tick && action[1])
            begin
               if (at_max)
               begin
                  next_oc = ocr_max ? ~up_lvl : up_lvl; // R18 R17
               end
               else if (match)
               begin
                  next_oc = (count_up || at_bottom) ? up_lvl : ~up_lvl; // R15 R17
               end
            end
         end
         default: next_oc = oc;
      endcase
   end

endmodule : tmr8_wavegen

`default_nettype wire

// [rtl/tmr8_timer.sv]
// 8-bit timer/counter with four counting and waveform modes
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// R1 - mode 0 counts up and rolls over
// R2 - mode 0 overflow flag set on wrap
// R3 - mode 2 clears after compare match
// R4 - mode 2 compare unbuffered, missed match wraps
// R5 - mode 2 action 1 toggles on match
// R6 - mode 2 overflow flag set on max wrap
// R7 - pin driven only when direction is output
// R8 - mode 3 counts up then wraps
// R9 - fast pwm clears on match, sets at wrap
// R10 - action 2 non-inverted, 3 inverted pwm
// R11 - fast pwm overflow flag at max
// R12 - fast pwm extreme compare values handled
// R13 - fast pwm action 1 toggles on match
// R14 - mode 1 up, one tick max, down
// R15 - phase pwm clears up, sets down
// R16 - phase pwm overflow flag at zero
// R17 - phase pwm extremes give constant levels
// R18 - at max take up-count match level
// R19 - tick is a clock enable, synchronous
// R20 - match sets compare flag, one clears
// R21 - pwm buffers compare value, others direct
// R22 - counter write beats clear and count
// R23 - action 0 leaves output unchanged
// R24 - buffer loads at wrap or at max
module tmr8_timer
   import tmr8_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic RESETN,
   input wire logic CE,
   input wire logic TIMER_TICK,
   input wire logic [1:0] WAVEFORM_MODE_SEL,
   input wire logic [1:0] OUTPUT_ACTION_SEL,
   input wire logic CMP_WR,
   input wire logic [TMR8_W-1:0] CMP_WDATA,
   input wire logic CNT_WR,
   input wire logic [TMR8_W-1:0] CNT_WDATA,
   input wire logic FORCE_MATCH,
   input wire logic OVF_CLR,
   input wire logic CMP_CLR,
   input wire logic PIN_DIR_OUT,
   output logic [TMR8_W-1:0] COUNT_VALUE,
   output logic [TMR8_W-1:0] COMPARE_VALUE,
   output logic [TMR8_W-1:0] COMPARE_BUF,
   output logic OVERFLOW_FLAG,
   output logic COMPARE_FLAG,
   output logic COMPARE_OUTPUT,
   output logic PIN_OUT,
   output logic PIN_OE
);

   // ****************************************************************
   // state of the block
   // ****************************************************************

   // every flip-flop of the timer lives in this one record
   typedef struct packed {
      logic [TMR8_W-1:0] cnt; // counter
      logic [TMR8_W-1:0] ocr; // active compare value
      logic [TMR8_W-1:0] ocr_buf; // buffered compare value
      logic ovf; // overflow flag
      logic cmpf; // compare flag
      logic oc; // internal compare output state
      logic blk; // match blocked after a counter write
      tmr8_dir_t dir; // dual-slope direction
   } tmr8_state_t;

   tmr8_state_t st; // registered state
   tmr8_state_t next_st; // next state

   // ****************************************************************
   // decoded conditions
   // ****************************************************************

   logic tick_ev; // one counting step in this cycle
   logic at_max; // counter at its top
   logic at_bottom; // counter at zero
   logic match; // comparator hit, unless blocked
   logic pwm; // a buffered mode is active
   logic ovf_set; // overflow event this cycle
   logic cmp_set; // compare flag event this cycle
   logic force_ev; // forced match, non-pwm only
   logic wave_oc; // next compare output level

   // the tick only qualifies the system clock, no second clock domain
   assign tick_ev = CE && TIMER_TICK; // R19
   assign at_max = st.cnt == TMR8_MAX;
   assign at_bottom = st.cnt == TMR8_BOTTOM;
   // a counter write suppresses the next match, so ocr can equal cnt safely
   assign match = (st.cnt == st.ocr) && !st.blk;
   assign pwm = tmr8_is_pwm(WAVEFORM_MODE_SEL);

   // overflow sits at max in three modes and at bottom in the dual slope
   assign ovf_set = tick_ev && ((WAVEFORM_MODE_SEL == TMR8_MODE_PHASE) ? at_bottom : at_max); // R2 R6 R11 R16

   // a match present at a tick raises the flag at that tick
   assign cmp_set = tick_ev && match; // R20

   // forcing is meaningless in pwm, where it is ignored
   assign force_ev = CE && FORCE_MATCH && !pwm;

   // ****************************************************************
   // waveform generator
   // ****************************************************************

   // the output level rule is kept apart from the counter sequencing
   tmr8_wavegen u_wave (
      .mode (WAVEFORM_MODE_SEL),
      .action (OUTPUT_ACTION_SEL),
      .oc (st.oc),
      .tick (tick_ev),
      .match (match),
      .at_max (at_max),
      .at_bottom (at_bottom),
      .count_up (st.dir == TMR8_UP),
      .ocr_max (st.ocr == TMR8_MAX),
      .force_match (force_ev),
      .next_oc (wave_oc)
   );

   // ****************************************************************
   // next-state logic
   // ****************************************************************

   // with ce low nothing moves; all state holds
   always_comb
   begin
      next_st = st;
      if (CE)
      begin
         if (tick_ev)
         begin
            // the block lasts exactly one tick
            next_st.blk = 1'b0;
            case (WAVEFORM_MODE_SEL)
               // free running: up only, natural wrap
               TMR8_MODE_NORMAL:
               begin
                  next_st.cnt = st.cnt + TMR8_STEP; // R1
               end
               // ocr acts as top; a top below cnt is missed until the wrap
               TMR8_MODE_MATCH:
               begin
                  if (match)
                  begin
                     next_st.cnt = TMR8_BOTTOM; // R3
                  end
                  else
                  begin
                     next_st.cnt = st.cnt + TMR8_STEP; // R4
                  end
               end
               // single slope with buffer transfer at the wrap
               TMR8_MODE_FAST:
               begin
                  if (at_max)
                  begin
                     next_st.cnt = TMR8_BOTTOM; // R8
                     next_st.ocr = st.ocr_buf; // R24
                  end
                  else
                  begin
                     next_st.cnt = st.cnt + TMR8_STEP;
                  end
               end
               // dual slope, max held for one tick, transfer at max
               TMR8_MODE_PHASE:
               begin
                  if (st.dir == TMR8_UP)
                  begin
                     if (at_max)
                     begin
                        next_st.dir = TMR8_DOWN; // R14
                        next_st.cnt = st.cnt - TMR8_STEP;
                        next_st.ocr = st.ocr_buf; // R24
                     end
                     else
                     begin
                        next_st.cnt = st.cnt + TMR8_STEP;
                     end
                  end
                  else if (at_bottom)
                  begin
                     next_st.dir = TMR8_UP; // R14
                     next_st.cnt = st.cnt + TMR8_STEP;
                  end
                  else
                  begin
                     next_st.cnt = st.cnt - TMR8_STEP;
                  end
               end
               default: next_st.cnt = st.cnt;
            endcase
         end

         // a set arriving together with a clear is kept
         next_st.ovf = ovf_set || (st.ovf && !OVF_CLR);
         next_st.cmpf = cmp_set || (st.cmpf && !CMP_CLR); // R20

         next_st.oc = wave_oc;

         // pwm writes land in the buffer only; other modes write through
         if (CMP_WR)
         begin
            next_st.ocr_buf = CMP_WDATA;
            if (!pwm)
            begin
               next_st.ocr = CMP_WDATA; // R21 R4
            end
         end

         // applied last so it overrides any clear or count of this cycle
         if (CNT_WR)
         begin
            next_st.cnt = CNT_WDATA; // R22
            next_st.blk = 1'b1;
         end
      end
   end

   // ****************************************************************
   // state register
   // ****************************************************************

   // synchronous active-low reset clears every field
   always_ff @(posedge CLK_SYS)
   begin
      if (!RESETN)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************

   assign COUNT_VALUE = st.cnt;
   assign COMPARE_VALUE = st.ocr;
   assign COMPARE_BUF = st.ocr_buf;
   assign OVERFLOW_FLAG = st.ovf;
   assign COMPARE_FLAG = st.cmpf;
   assign COMPARE_OUTPUT = st.oc;
   // the internal level survives while the pin is an input
   assign PIN_OUT = st.oc; // R7
   assign PIN_OE = PIN_DIR_OUT; // R7

   // ****************************************************************
   // checks
   // ****************************************************************

   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!RESETN);

   a_normal_wrap: // R1
      assert property (tick_ev && (WAVEFORM_MODE_SEL == TMR8_MODE_NORMAL) && at_max && !CNT_WR
                       |=> (st.cnt == TMR8_BOTTOM) && st.ovf)
      else $error("free-running wrap or overflow wrong");

   a_match_clear: // R3
      assert property (tick_ev && (WAVEFORM_MODE_SEL == TMR8_MODE_MATCH) && match && !CNT_WR
                       |=> st.cnt == TMR8_BOTTOM)
      else $error("clear on match missing");

   a_match_toggle: // R5
      assert property (tick_ev && (WAVEFORM_MODE_SEL == TMR8_MODE_MATCH) && match
                       && (OUTPUT_ACTION_SEL == TMR8_ACT_TOGGLE) |=> st.oc != $past(st.oc))
      else $error("toggle on match missing");

   a_fast_wrap: // R8
      assert property (tick_ev && (WAVEFORM_MODE_SEL == TMR8_MODE_FAST) && at_max && !CNT_WR
                       |=> (st.cnt == TMR8_BOTTOM) && st.ovf && (st.ocr == $past(st.ocr_buf)))
      else $error("fast pwm wrap wrong");

   a_fast_set: // R9
      assert property (tick_ev && (WAVEFORM_MODE_SEL == TMR8_MODE_FAST) && at_max
                       && (OUTPUT_ACTION_SEL == TMR8_ACT_CLEAR) |=> st.oc)
      else $error("fast pwm output not set at wrap");

   a_phase_turn: // R14
      assert property (tick_ev && (WAVEFORM_MODE_SEL == TMR8_MODE_PHASE) && at_max
                       && (st.dir == TMR8_UP) && !CNT_WR
                       |=> (st.cnt == TMR8_MAX - TMR8_STEP) && (st.dir == TMR8_DOWN))
      else $error("dual slope turn at max wrong");

   a_phase_ovf: // R16
      assert property (tick_ev && (WAVEFORM_MODE_SEL == TMR8_MODE_PHASE) && at_bottom |=> st.ovf)
      else $error("overflow at bottom missing");

   a_cmp_flag: // R20
      assert property (tick_ev && match |=> st.cmpf)
      else $error("compare flag not set");

   a_cnt_write: // R22
      assert property (CE && CNT_WR |=> (st.cnt == $past(CNT_WDATA)) && !match)
      else $error("counter write lost or match not blocked");

   a_direct_ocr: // R21
      assert property (CE && CMP_WR && !pwm |=> st.ocr == $past(CMP_WDATA))
      else $error("direct compare write lost");

   a_no_action: // R23
      assert property (CE && (OUTPUT_ACTION_SEL == TMR8_ACT_NONE) |=> st.oc == $past(st.oc))
      else $error("output moved with no action");

   a_freeze_all: // R19
      assert property (!CE |=> $stable(st))
      else $error("state moved with ce low");

   // the wrap raises overflow even when the top is the compare value
   a_match_ovf: // R6
      assert property (tick_ev && (WAVEFORM_MODE_SEL == TMR8_MODE_MATCH) && at_max |=> st.ovf)
      else $error("overflow at wrap missing in clear-on-match mode");

   // only the clear strobe may drop the overflow flag
   a_ovf_sticky: // R2
      assert property (CE && st.ovf && !OVF_CLR |=> st.ovf)
      else $error("overflow flag cleared by hardware");

   a_fast_toggle: // R13
      assert property (tick_ev && (WAVEFORM_MODE_SEL == TMR8_MODE_FAST) && match
                       && (OUTPUT_ACTION_SEL == TMR8_ACT_TOGGLE) |=> st.oc != $past(st.oc))
      else $error("fast pwm toggle on match missing");

   // transfer at the top keeps both slopes of a period symmetric
   a_phase_load: // R24
      assert property (tick_ev && (WAVEFORM_MODE_SEL == TMR8_MODE_PHASE) && at_max && (st.dir == TMR8_UP)
                       |=> st.ocr == $past(st.ocr_buf))
      else $error("dual slope buffer not loaded at top");

   // a mid-period write must not reach the comparator
   a_pwm_buffer: // R21
      assert property (CE && CMP_WR && pwm && !tick_ev |=> st.ocr == $past(st.ocr))
      else $error("buffered compare value applied early");

endmodule : tmr8_timer

`default_nettype wire

// [verification/tb_top.sv]
// self-checking testbench of the 8-bit waveform timer
`timescale 1ns/10ps
`default_nettype none

// one compare: counts it, reports and counts a mismatch
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin err_count++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end

module tb_top
   import tmr8_pkg::*;
;
   // ****************************************************************
   // stimulus and design hookup
   // ****************************************************************
   logic CLK_SYS, RESETN, CE, TIMER_TICK, CMP_WR, CNT_WR, FORCE_MATCH, OVF_CLR, CMP_CLR, PIN_DIR_OUT;
   logic [1:0] WAVEFORM_MODE_SEL, OUTPUT_ACTION_SEL;
   logic [7:0] CMP_WDATA, CNT_WDATA, COUNT_VALUE, COMPARE_VALUE, COMPARE_BUF;
   logic OVERFLOW_FLAG, COMPARE_FLAG, COMPARE_OUTPUT, PIN_OUT, PIN_OE;
   int err_count = 0; // mismatches seen
   int comparisons = 0; // compares made
   // strobe patterns: tick, compare write, counter write, force, both flag clears
   localparam logic [5:0] s_tick = 6'h20, s_cw = 6'h10, s_nw = 6'h08, s_frc = 6'h04, s_clr = 6'h03;
   // one ordinary case: setup, then one tick and the state it must leave
   typedef struct packed {
      logic [1:0] m, a;
      logic l;
      logic [7:0] cmp, cnt, ecnt;
      logic eovf, ecf, eout;
   } tmr8_row_t;
   tmr8_row_t rows [0:13] = '{
      '{2'h0, 2'h0, 1'b0, 8'h10, 8'hFF, 8'h00, 1'b1, 1'b0, 1'b0},
      '{2'h0, 2'h0, 1'b1, 8'h10, 8'h10, 8'h11, 1'b0, 1'b1, 1'b1},
      '{2'h2, 2'h1, 1'b0, 8'h03, 8'h03, 8'h00, 1'b0, 1'b1, 1'b1},
      '{2'h2, 2'h0, 1'b1, 8'h80, 8'hFF, 8'h00, 1'b1, 1'b0, 1'b1},
      '{2'h2, 2'h2, 1'b1, 8'h20, 8'h20, 8'h00, 1'b0, 1'b1, 1'b0},
      '{2'h2, 2'h3, 1'b0, 8'h20, 8'h20, 8'h00, 1'b0, 1'b1, 1'b1},
      '{2'h0, 2'h1, 1'b1, 8'h05, 8'h05, 8'h06, 1'b0, 1'b1, 1'b0},
      '{2'h3, 2'h2, 1'b0, 8'h40, 8'hFF, 8'h00, 1'b1, 1'b0, 1'b1},
      '{2'h3, 2'h2, 1'b1, 8'h40, 8'h40, 8'h41, 1'b0, 1'b1, 1'b0},
      '{2'h3, 2'h3, 1'b1, 8'h40, 8'hFF, 8'h00, 1'b1, 1'b0, 1'b0},
      '{2'h3, 2'h1, 1'b0, 8'h40, 8'h40, 8'h41, 1'b0, 1'b1, 1'b1},
      '{2'h1, 2'h2, 1'b1, 8'h40, 8'h40, 8'h41, 1'b0, 1'b1, 1'b0},
      '{2'h1, 2'h3, 1'b0, 8'h40, 8'h40, 8'h41, 1'b0, 1'b1, 1'b1},
      '{2'h1, 2'h0, 1'b1, 8'h40, 8'h00, 8'h01, 1'b1, 1'b0, 1'b1}
   };

   tmr8_timer u_tmr8_timer (
      .CLK_SYS(CLK_SYS), .RESETN(RESETN), .CE(CE), .TIMER_TICK(TIMER_TICK),
      .WAVEFORM_MODE_SEL(WAVEFORM_MODE_SEL), .OUTPUT_ACTION_SEL(OUTPUT_ACTION_SEL),
      .CMP_WR(CMP_WR), .CMP_WDATA(CMP_WDATA), .CNT_WR(CNT_WR), .CNT_WDATA(CNT_WDATA),
      .FORCE_MATCH(FORCE_MATCH), .OVF_CLR(OVF_CLR), .CMP_CLR(CMP_CLR), .PIN_DIR_OUT(PIN_DIR_OUT),
      .COUNT_VALUE(COUNT_VALUE), .COMPARE_VALUE(COMPARE_VALUE), .COMPARE_BUF(COMPARE_BUF),
      .OVERFLOW_FLAG(OVERFLOW_FLAG), .COMPARE_FLAG(COMPARE_FLAG), .COMPARE_OUTPUT(COMPARE_OUTPUT),
      .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE)
   );

   // ****************************************************************
   // clock and watchdog
   // ****************************************************************
   // 50 MHz system clock
   initial
   begin
      CLK_SYS = 1'b0;
      forever #10 CLK_SYS = ~CLK_SYS;
   end

   // about 9k cycles are needed; the margin covers a slow but legal design
   initial
   begin
      repeat (60000) @(posedge CLK_SYS);
      err_count++;
      tally_and_finish();
   end

   // ****************************************************************
   // helpers
   // ****************************************************************
   // verdict and end of run
   task automatic tally_and_finish();
      if (err_count == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish

   // one-cycle strobes raised after an edge, lowered at the next, then settle
   task automatic drv(input logic [5:0] s, input logic [7:0] cd, input logic [7:0] nd);
      @(posedge CLK_SYS);
      {TIMER_TICK, CMP_WR, CNT_WR, FORCE_MATCH, OVF_CLR, CMP_CLR} <= s;
      CMP_WDATA <= cd;
      CNT_WDATA <= nd;
      @(posedge CLK_SYS);
      {TIMER_TICK, CMP_WR, CNT_WR, FORCE_MATCH, OVF_CLR, CMP_CLR} <= 6'h00;
      #1;
   endtask : drv

   // forced output level, direct compare load, count reached by one blocked tick
   task automatic prep(input logic [1:0] m, a, input logic l, input logic [7:0] cmp, cnt);
      @(posedge CLK_SYS);
      WAVEFORM_MODE_SEL <= TMR8_MODE_NORMAL;
      OUTPUT_ACTION_SEL <= l ? TMR8_ACT_SET : TMR8_ACT_CLEAR;
      drv(s_frc, 8'h00, 8'h00);
      drv(s_cw, cmp, 8'h00);
      drv(s_nw, 8'h00, cnt - 8'h01);
      drv(s_tick, 8'h00, 8'h00);
      @(posedge CLK_SYS);
      WAVEFORM_MODE_SEL <= m;
      OUTPUT_ACTION_SEL <= a;
      drv(s_clr, 8'h00, 8'h00);
      `CHK("flag_clear", 2'b00, {OVERFLOW_FLAG, COMPARE_FLAG})
   endtask : prep

   // 520 ticks from a count of 8'h20 (two fast or one dual-slope pwm period), against a model
   task automatic run_model(input logic [1:0] m, a, input logic [7:0] cmp);
      logic [7:0] c;
      logic o, up, eo, ec;
      prep(m, a, 1'b1, cmp, 8'h20);
      c = 8'h20;
      o = 1'b1;
      up = 1'b1;
      repeat (520)
      begin
         ec = (c == cmp);
         eo = (m == TMR8_MODE_FAST) ? (c == TMR8_MAX) : (c == TMR8_BOTTOM);
         if (m == TMR8_MODE_FAST)
         begin
            if (c == TMR8_MAX && a[1]) o = (a == TMR8_ACT_CLEAR);
            else if (ec) o = (a == TMR8_ACT_TOGGLE) ? ~o : (a == TMR8_ACT_SET);
            c = c + 8'h01;
         end
         else
         begin
            // at the top the up-match level, unless the top is the compare value
            if (c == TMR8_MAX) o = (cmp == TMR8_MAX) ? (a == TMR8_ACT_CLEAR) : (a == TMR8_ACT_SET);
            else if (ec) o = (up || c == 8'h00) ? (a == TMR8_ACT_SET) : (a == TMR8_ACT_CLEAR);
            if (c == TMR8_MAX) up = 1'b0;
            if (c == TMR8_BOTTOM) up = 1'b1;
            c = up ? c + 8'h01 : c - 8'h01;
         end
         drv(s_tick | s_clr, 8'h00, 8'h00);
         `CHK("model_count", c, COUNT_VALUE)
         `CHK("model_output", o, COMPARE_OUTPUT)
         `CHK("model_flags", {eo, ec}, {OVERFLOW_FLAG, COMPARE_FLAG})
      end
   endtask : run_model

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial
   begin
      {RESETN, CE, TIMER_TICK, CMP_WR, CNT_WR, FORCE_MATCH, OVF_CLR, CMP_CLR, PIN_DIR_OUT} = 9'h000;
      {WAVEFORM_MODE_SEL, OUTPUT_ACTION_SEL, CMP_WDATA, CNT_WDATA} = 20'h00000;
      repeat (16) @(posedge CLK_SYS);
      RESETN <= 1'b1;
      CE <= 1'b1;
      #1;
      `CHK("reset_state", 27'h0, {COUNT_VALUE, COMPARE_VALUE, COMPARE_BUF, OVERFLOW_FLAG, COMPARE_FLAG, COMPARE_OUTPUT})
      // ordinary cases
      foreach (rows[i])
      begin
         prep(rows[i].m, rows[i].a, rows[i].l, rows[i].cmp, rows[i].cnt);
         drv(s_tick, 8'h00, 8'h00);
         `CHK("row_count", rows[i].ecnt, COUNT_VALUE)
         `CHK("row_flags", {rows[i].eovf, rows[i].ecf}, {OVERFLOW_FLAG, COMPARE_FLAG})
         `CHK("row_output", rows[i].eout, COMPARE_OUTPUT)
      end
      // pin driven only with output direction; the level is kept inside
      `CHK("pin_hidden", 2'b01, {PIN_OE, PIN_OUT})
      @(posedge CLK_SYS);
      PIN_DIR_OUT <= 1'b1;
      #1;
      `CHK("pin_shown", 2'b11, {PIN_OE, PIN_OUT})
      // pwm periods: polarity, extremes, toggle and the top-of-count level
      run_model(TMR8_MODE_PHASE, TMR8_ACT_CLEAR, 8'h10);
      run_model(TMR8_MODE_PHASE, TMR8_ACT_SET, 8'h10);
      run_model(TMR8_MODE_PHASE, TMR8_ACT_CLEAR, 8'h00);
      run_model(TMR8_MODE_PHASE, TMR8_ACT_CLEAR, 8'hFF);
      run_model(TMR8_MODE_FAST, TMR8_ACT_CLEAR, 8'h00);
      run_model(TMR8_MODE_FAST, TMR8_ACT_SET, 8'hFF);
      run_model(TMR8_MODE_FAST, TMR8_ACT_TOGGLE, 8'h40);
      // compare lowered below the count: full wrap before the match
      prep(TMR8_MODE_MATCH, TMR8_ACT_NONE, 1'b0, 8'h60, 8'h50);
      drv(s_cw, 8'h20, 8'h00);
      repeat (176) drv(s_tick, 8'h00, 8'h00);
      `CHK("late_wrap", 10'h002, {COUNT_VALUE, OVERFLOW_FLAG, COMPARE_FLAG})
      repeat (33) drv(s_tick, 8'h00, 8'h00);
      `CHK("late_match", 9'h001, {COUNT_VALUE, COMPARE_FLAG})
      // buffered compare: fast pwm loads at wrap
      prep(TMR8_MODE_FAST, TMR8_ACT_CLEAR, 1'b0, 8'h40, 8'h10);
      drv(s_cw, 8'h80, 8'h00);
      `CHK("fast_buffered", 16'h8040, {COMPARE_BUF, COMPARE_VALUE})
      repeat (240) drv(s_tick, 8'h00, 8'h00);
      `CHK("fast_loaded", 16'h0080, {COUNT_VALUE, COMPARE_VALUE})
      // buffered compare: dual slope loads at the top
      prep(TMR8_MODE_PHASE, TMR8_ACT_CLEAR, 1'b0, 8'h40, 8'hF0);
      drv(s_cw, 8'h80, 8'h00);
      repeat (15) drv(s_tick, 8'h00, 8'h00);
      `CHK("phase_held", 16'hFF40, {COUNT_VALUE, COMPARE_VALUE})
      drv(s_tick, 8'h00, 8'h00);
      `CHK("phase_loaded", 16'hFE80, {COUNT_VALUE, COMPARE_VALUE})
      // counter write beats the tick and blocks the next match
      prep(TMR8_MODE_MATCH, TMR8_ACT_NONE, 1'b0, 8'h30, 8'h10);
      drv(s_tick | s_nw, 8'h00, 8'h30);
      `CHK("write_wins", 8'h30, COUNT_VALUE)
      drv(s_tick, 8'h00, 8'h00);
      `CHK("match_blocked", 9'h062, {COUNT_VALUE, COMPARE_FLAG})
      // tick is only an enable of the system clock: frozen when disabled
      @(posedge CLK_SYS);
      CE <= 1'b0;
      drv(s_tick, 8'h00, 8'h00);
      `CHK("frozen", 8'h31, COUNT_VALUE)
      tally_and_finish();
   end
endmodule : tb_top

`default_nettype wire
